/* File: rtl/ushb_consts.svh */
// Constants of the UART shadow buffer access block: addresses, fields, counts
// Assumes: included by bare name wherever a constant is needed
// Contract
// - Every alias location reads the receive buffer
// - Every alias location writes the transmit holding
// - Read bits 7:0 give serial or infrared byte
// - Non-FIFO: new byte overwrites, overrun flagged
// - FIFO mode: read returns receive FIFO head
// - Full receive FIFO: keep contents, drop, overrun
// - Written byte leaves on serial or infrared output
// - Non-FIFO: one write clears holding-empty flag
// - Non-FIFO: further writes replace pending byte
// - FIFO mode: accept depth bytes, default sixteen
// - Writes while transmit FIFO full are discarded
`ifndef USHB_CONSTS_SVH
`define USHB_CONSTS_SVH
`define USHB_ALIAS_FIRST 32'h5000_1030
`define USHB_ALIAS_2     32'h5000_1038
`define USHB_ALIAS_3     32'h5000_103c
`define USHB_ALIAS_LAST  32'h5000_106c
`define USHB_CTRL_ADDR   32'h5000_1080
`define USHB_LSR_ADDR    32'h5000_1084
`define USHB_ISTAT_ADDR  32'h5000_1088
`define USHB_IMASK_ADDR  32'h5000_108c
`define USHB_CTRL_FIFO_EN 0
`define USHB_CTRL_IR_MODE 1
`define USHB_LSR_DR      0
`define USHB_LSR_OE      1
`define USHB_LSR_TX_HOLDING_EMPTY_FLAG    5
`define USHB_LSR_TEMT    6
`define USHB_EV_RX       0
`define USHB_EV_OE       1
`define USHB_EV_TX_HOLDING_EMPTY_FLAG     2
`define USHB_EV_W        3
`define USHB_BYTE_MSB    7
`define USHB_FIFO_DEPTH  16
`define USHB_CLK_HZ      20000000
`define USHB_BAUD        115200
`endif

/* File: rtl/ushb_pkg.sv */
// Types shared by the UART shadow buffer access block
// Assumes: compiled before every other design file
package ushb_pkg;
    typedef enum logic [1:0] {
        USHB_IDLE  = 2'h0,
        USHB_START = 2'h1,
        USHB_DATA  = 2'h3,
        USHB_STOP  = 2'h2
    } ushb_bit_st_t;
    typedef logic [7:0] ushb_byte_t;
endpackage

/* File: rtl/ushb_fifo_if.sv */
// Signals between the block's control logic and one byte FIFO
// Assumes: ctl and mem ends share one clock
interface ushb_fifo_if #(
    parameter int DEPTH = 16
);
    localparam int CW = $clog2(DEPTH + 1);
    logic                push;
    logic                pop;
    logic                ovw;
    logic                flush;
    logic [CW-1:0]       lim;
    ushb_pkg::ushb_byte_t wdata;
    ushb_pkg::ushb_byte_t rdata;
    logic [CW-1:0]       count;
    logic                empty;
    logic                full;
    modport ctl (output push, pop, ovw, flush, lim, wdata, input rdata, count, empty, full);
    modport mem (input push, pop, ovw, flush, lim, wdata, output rdata, count, empty, full);
endinterface

/* File: rtl/ushb_fifo.sv */
// Byte FIFO with registered head and a run-time fill limit
// Assumes: lim is 1..DEPTH; a push while full with ovw set drops the oldest byte
`include "ushb_consts.svh"
module ushb_fifo #(
    parameter int DEPTH = `USHB_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    ushb_fifo_if.mem f
);
    import ushb_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [AW-1:0]         rd;
        logic [AW-1:0]         wr;
        logic [CW-1:0]         cnt;
        ushb_byte_t            head;
    } ushb_fifo_st_t;
    ushb_fifo_st_t st_ff;
    ushb_fifo_st_t nxt_st;
    logic          full;
    logic          do_pop;
    logic          do_push;

    always_comb
    begin
        nxt_st  = st_ff;
        full    = (st_ff.cnt >= f.lim);
        do_pop  = (f.pop && (st_ff.cnt != '0)) || (f.push && full && f.ovw);
        do_push = f.push && (!full || f.ovw);
        if (do_push)
        begin
            nxt_st.mem[st_ff.wr] = f.wdata;
            nxt_st.wr = (st_ff.wr == AW'(DEPTH - 1)) ? '0 : st_ff.wr + 1'b1;
        end
        if (do_pop)
        begin
            nxt_st.rd = (st_ff.rd == AW'(DEPTH - 1)) ? '0 : st_ff.rd + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + CW'(do_push) - CW'(do_pop);
        if (f.flush)
        begin
            nxt_st.rd  = '0;
            nxt_st.wr  = '0;
            nxt_st.cnt = '0;
        end
        // Head follows the next read pointer, so a write into an empty FIFO shows at once
        nxt_st.head = nxt_st.mem[nxt_st.rd];
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign f.rdata = st_ff.head;
    assign f.count = st_ff.cnt;
    assign f.empty = (st_ff.cnt == '0);
    assign f.full  = full;
endmodule // ushb_fifo

/* File: rtl/ushb_rx.sv */
// Serial receiver: synchronises both line pins and assembles 8N1 bytes
// Assumes: infrared input idles low and pulses high for a zero bit
`include "ushb_consts.svh"
module ushb_rx #(
    parameter int BIT_CYC = `USHB_CLK_HZ / `USHB_BAUD
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // Line pins and mode
    input  wire logic        ser_rx_i,
    input  wire logic        ir_rx_i,
    input  wire logic        ir_mode_i,
    // Received byte
    output ushb_pkg::ushb_byte_t data_o,
    output logic             valid_o
);
    import ushb_pkg::*;
    typedef struct packed {
        logic [1:0]   ser_s;
        logic [1:0]   ir_s;
        ushb_bit_st_t st;
        logic [15:0]  tmr;
        logic [2:0]   idx;
        ushb_byte_t   sh;
        logic         vld;
    } ushb_rx_st_t;
    ushb_rx_st_t st_ff;
    ushb_rx_st_t nxt_st;
    logic        line;

    always_comb
    begin
        nxt_st       = st_ff;
        nxt_st.ser_s = {st_ff.ser_s[0], ser_rx_i};
        nxt_st.ir_s  = {st_ff.ir_s[0], ir_rx_i};
        nxt_st.vld   = 1'b0;
        line         = ir_mode_i ? !st_ff.ir_s[1] : st_ff.ser_s[1];
        if (st_ff.st != USHB_IDLE && st_ff.tmr != '0)
            nxt_st.tmr = st_ff.tmr - 1'b1;
        case (st_ff.st)
            USHB_IDLE:
                if (!line)
                begin
                    nxt_st.st  = USHB_START;
                    nxt_st.tmr = 16'(BIT_CYC / 2);
                end
            USHB_START:
                if (st_ff.tmr == '0)
                begin
                    nxt_st.st  = line ? USHB_IDLE : USHB_DATA;
                    nxt_st.tmr = 16'(BIT_CYC - 1);
                    nxt_st.idx = '0;
                end
            USHB_DATA:
                if (st_ff.tmr == '0)
                begin
                    nxt_st.sh  = {line, st_ff.sh[`USHB_BYTE_MSB:1]};
                    nxt_st.tmr = 16'(BIT_CYC - 1);
                    nxt_st.idx = st_ff.idx + 1'b1;
                    if (st_ff.idx == 3'(`USHB_BYTE_MSB))
                        nxt_st.st = USHB_STOP;
                end
            USHB_STOP:
                if (st_ff.tmr == '0)
                begin
                    nxt_st.vld = line;
                    nxt_st.st  = USHB_IDLE;
                end
            default:
                nxt_st.st = USHB_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_ff       <= '0;
            st_ff.ser_s <= 2'h3;
        end
        else
            st_ff <= nxt_st;
    end

    assign data_o  = st_ff.sh;
    assign valid_o = st_ff.vld;
endmodule // ushb_rx

/* File: rtl/ushb_top.sv */
// UART shadow buffer access: APB alias window onto receive buffer and transmit holding
// Assumes: APB3 master on clk_i; line pins asynchronous to clk_i
//
// Register access over APB was decided locally.
`include "ushb_consts.svh"
module ushb_top #(
    parameter int FIFO_DEPTH = `USHB_FIFO_DEPTH,
    parameter int BIT_CYC    = `USHB_CLK_HZ / `USHB_BAUD
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Serial and infrared lines
    input  wire logic        ser_rx_i,
    input  wire logic        ir_rx_i,
    output logic             ser_tx_o,
    output logic             ir_tx_n_o,
    // Interrupt
    output logic             irq_o
);
    import ushb_pkg::*;
    localparam int CW = $clog2(FIFO_DEPTH + 1);
    typedef struct packed {
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        logic                  fifo_en;
        logic                  ir_mode;
        logic                  oe;
        logic [`USHB_EV_W-1:0] istat;
        logic [`USHB_EV_W-1:0] imask;
        logic                  irq;
        logic                  tx_busy_d;
        ushb_bit_st_t          tst;
        logic [15:0]           ttmr;
        logic [2:0]            tidx;
        ushb_byte_t            tsh;
        logic                  tx_line;
        logic                  ser_tx;
        logic                  ir_tx_n;
    } ushb_top_st_t;
    ushb_top_st_t          st_ff;
    ushb_top_st_t          nxt_st;
    logic                  setup;
    logic                  acc;
    logic                  is_alias;
    logic                  rx_vld;
    ushb_byte_t            rx_data;
    logic                  ovr;
    logic [`USHB_EV_W-1:0] ev;
    logic [`USHB_EV_W-1:0] w1c;

    ushb_fifo_if #(.DEPTH(FIFO_DEPTH)) rxf();
    ushb_fifo_if #(.DEPTH(FIFO_DEPTH)) txf();

    ushb_fifo #(.DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .f      (rxf)
    );

    ushb_fifo #(.DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .f      (txf)
    );

    ushb_rx #(.BIT_CYC(BIT_CYC)) u_rx (
        .clk_i     (clk_i),
        .rstn_i    (rstn_i),
        .ser_rx_i  (ser_rx_i),
        .ir_rx_i   (ir_rx_i),
        .ir_mode_i (st_ff.ir_mode),
        .data_o    (rx_data),
        .valid_o   (rx_vld)
    );

    always_comb
    begin
        nxt_st   = st_ff;
        setup    = psel_i && !penable_i;
        acc      = psel_i && penable_i && st_ff.pready;
        is_alias = (paddr_i >= `USHB_ALIAS_FIRST) && (paddr_i <= `USHB_ALIAS_LAST)
                   && (paddr_i[1:0] == 2'h0);
        // Zero-wait answer: ready in the first access cycle
        nxt_st.pready = setup;
        if (setup)
        begin
            nxt_st.prdata  = '0;
            nxt_st.pslverr = 1'b0;
            if (is_alias)
                nxt_st.prdata[`USHB_BYTE_MSB:0] = rxf.rdata;
            else if (paddr_i == `USHB_CTRL_ADDR)
            begin
                nxt_st.prdata[`USHB_CTRL_FIFO_EN] = st_ff.fifo_en;
                nxt_st.prdata[`USHB_CTRL_IR_MODE] = st_ff.ir_mode;
            end
            else if (paddr_i == `USHB_LSR_ADDR)
            begin
                nxt_st.prdata[`USHB_LSR_DR]   = !rxf.empty;
                nxt_st.prdata[`USHB_LSR_OE]   = st_ff.oe;
                nxt_st.prdata[`USHB_LSR_TX_HOLDING_EMPTY_FLAG] = txf.empty;
                nxt_st.prdata[`USHB_LSR_TEMT] = txf.empty && st_ff.tst == USHB_IDLE;
            end
            else if (paddr_i == `USHB_ISTAT_ADDR)
                nxt_st.prdata[`USHB_EV_W-1:0] = st_ff.istat;
            else if (paddr_i == `USHB_IMASK_ADDR)
                nxt_st.prdata[`USHB_EV_W-1:0] = st_ff.imask;
            else
                nxt_st.pslverr = 1'b1;
        end

        // Receive path: non-FIFO mode is a one-deep buffer that overwrites
        rxf.lim   = st_ff.fifo_en ? CW'(FIFO_DEPTH) : CW'(1);
        rxf.push  = rx_vld;
        rxf.wdata = rx_data;
        rxf.ovw   = !st_ff.fifo_en;
        rxf.pop   = acc && !pwrite_i && is_alias;
        ovr       = rx_vld && rxf.full;

        // Transmit path: alias writes carry only bits 7:0
        txf.lim   = st_ff.fifo_en ? CW'(FIFO_DEPTH) : CW'(1);
        txf.push  = acc && pwrite_i && is_alias;
        txf.wdata = pwdata_i[`USHB_BYTE_MSB:0];
        txf.ovw   = !st_ff.fifo_en;
        txf.pop   = (st_ff.tst == USHB_IDLE) && !txf.empty;

        // Control register; a change of FIFO enable empties both FIFOs
        rxf.flush = 1'b0;
        if (acc && pwrite_i && paddr_i == `USHB_CTRL_ADDR)
        begin
            nxt_st.fifo_en = pwdata_i[`USHB_CTRL_FIFO_EN];
            nxt_st.ir_mode = pwdata_i[`USHB_CTRL_IR_MODE];
            rxf.flush      = pwdata_i[`USHB_CTRL_FIFO_EN] != st_ff.fifo_en;
        end
        txf.flush = rxf.flush;
        if (acc && pwrite_i && paddr_i == `USHB_IMASK_ADDR)
            nxt_st.imask = pwdata_i[`USHB_EV_W-1:0];

        // Overrun clears on a status read; a new overrun wins
        if (acc && !pwrite_i && paddr_i == `USHB_LSR_ADDR)
            nxt_st.oe = 1'b0;
        if (ovr)
            nxt_st.oe = 1'b1;

        // Sticky events, write one to clear, set wins
        nxt_st.tx_busy_d      = !txf.empty;
        ev                    = '0;
        ev[`USHB_EV_RX]       = rx_vld;
        ev[`USHB_EV_OE]       = ovr;
        ev[`USHB_EV_TX_HOLDING_EMPTY_FLAG]     = txf.empty && st_ff.tx_busy_d;
        w1c                   = '0;
        if (acc && pwrite_i && paddr_i == `USHB_ISTAT_ADDR)
            w1c = pwdata_i[`USHB_EV_W-1:0];
        nxt_st.istat = (st_ff.istat & ~w1c) | ev;
        nxt_st.irq   = |(nxt_st.istat & nxt_st.imask);

        // Transmit shifter, 8N1, LSB first
        if (st_ff.tst != USHB_IDLE && st_ff.ttmr != '0)
            nxt_st.ttmr = st_ff.ttmr - 1'b1;
        case (st_ff.tst)
            USHB_IDLE:
                if (txf.pop)
                begin
                    nxt_st.tsh     = txf.rdata;
                    nxt_st.tst     = USHB_START;
                    nxt_st.ttmr    = 16'(BIT_CYC - 1);
                    nxt_st.tx_line = 1'b0;
                end
            USHB_START:
                if (st_ff.ttmr == '0)
                begin
                    nxt_st.tst     = USHB_DATA;
                    nxt_st.ttmr    = 16'(BIT_CYC - 1);
                    nxt_st.tidx    = '0;
                    nxt_st.tx_line = st_ff.tsh[0];
                end
            USHB_DATA:
                if (st_ff.ttmr == '0)
                begin
                    nxt_st.ttmr = 16'(BIT_CYC - 1);
                    nxt_st.tidx = st_ff.tidx + 1'b1;
                    nxt_st.tsh  = {1'b0, st_ff.tsh[`USHB_BYTE_MSB:1]};
                    if (st_ff.tidx == 3'(`USHB_BYTE_MSB))
                    begin
                        nxt_st.tst     = USHB_STOP;
                        nxt_st.tx_line = 1'b1;
                    end
                    else
                        nxt_st.tx_line = st_ff.tsh[1];
                end
            USHB_STOP:
                if (st_ff.ttmr == '0)
                    nxt_st.tst = USHB_IDLE;
            default:
                nxt_st.tst = USHB_IDLE;
        endcase
        nxt_st.ser_tx  = nxt_st.ir_mode ? 1'b1 : nxt_st.tx_line;
        nxt_st.ir_tx_n = nxt_st.ir_mode ? nxt_st.tx_line : 1'b1;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_ff         <= '0;
            st_ff.tx_line <= 1'b1;
            st_ff.ser_tx  <= 1'b1;
            st_ff.ir_tx_n <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    assign prdata_o  = st_ff.prdata;
    assign pready_o  = st_ff.pready;
    assign pslverr_o = st_ff.pslverr;
    assign ser_tx_o  = st_ff.ser_tx;
    assign ir_tx_n_o = st_ff.ir_tx_n;
    assign irq_o     = st_ff.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_alias_rd;
        psel_i && penable_i && pready_o && !pwrite_i && is_alias;
    endsequence
    sequence s_alias_wr;
        psel_i && penable_i && pready_o && pwrite_i && is_alias;
    endsequence
    sequence s_tx_go;
        st_ff.tst == USHB_IDLE && !txf.empty;
    endsequence

    AST_RD_HI_ZERO: assert property (s_alias_rd |-> prdata_o[31:8] == '0)
        else $error("alias read upper bits not zero");
    AST_RD_HEAD: assert property (s_alias_rd and $past(!rxf.empty)
        |-> prdata_o[`USHB_BYTE_MSB:0] == rxf.rdata)
        else $error("alias read does not return receive head");
    AST_RD_POP: assert property (s_alias_rd and !rxf.empty && !rxf.push && !rxf.flush
        |=> rxf.count == $past(rxf.count) - 1)
        else $error("alias read did not pop receive buffer");
    AST_WR_PUSH: assert property (s_alias_wr |-> txf.push && txf.wdata == pwdata_i[7:0])
        else $error("alias write not passed to transmit holding");
    AST_RX_OVR: assert property (rx_vld && rxf.full |=> st_ff.oe && st_ff.istat[1])
        else $error("overrun not flagged");
    AST_RX_KEEP: assert property (st_ff.fifo_en && rx_vld && rxf.full && !rxf.pop
        && !rxf.flush |=> rxf.count == $past(rxf.count) && $stable(rxf.rdata))
        else $error("full receive FIFO lost contents");
    AST_TX_HOLDING_EMPTY_FLAG_CLR: assert property (!st_ff.fifo_en && txf.empty && txf.push
        && !txf.flush |=> !txf.empty ##1 ($past(st_ff.tst) != USHB_IDLE || txf.empty))
        else $error("holding-empty not cleared by write");
    AST_TX_OVW: assert property (!st_ff.fifo_en && txf.full && txf.push && !txf.pop
        && !txf.flush |=> txf.count == 1 && txf.rdata == $past(txf.wdata))
        else $error("pending transmit byte not replaced");
    AST_TX_LIM: assert property (txf.count <= (st_ff.fifo_en ? FIFO_DEPTH : 1))
        else $error("transmit FIFO above its depth");
    AST_TX_DROP: assert property (st_ff.fifo_en && txf.full && txf.push && !txf.pop
        && !txf.flush |=> txf.count == $past(txf.count))
        else $error("write into full transmit FIFO not dropped");
    AST_TX_START: assert property (s_tx_go |=> st_ff.tst == USHB_START
        && (st_ff.ir_mode ? !ir_tx_n_o : !ser_tx_o))
        else $error("start bit not driven on active line");
endmodule // ushb_top

/* File: testbench/ushb_peer_model.sv */
// Remote serial peer: sends 8N1 frames to the block and decodes what it sends back
// Assumes: bit timing taken from the bench clock; LSB first
module ushb_peer_model #(
    parameter int BIT_CYC = 8
) (
    input  wire logic clk_i,
    input  wire logic ser_tx_i,
    input  wire logic ir_tx_n_i,
    output logic      ser_rx_o,
    output logic      ir_rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import ushb_pkg::*;
    ushb_byte_t got_q[$];
    int         bad_frames = 0;
    ushb_byte_t b;
    logic       line;

    // The idle pin of the two is held high, so one decoder serves both modes
    assign line = ser_tx_i & ir_tx_n_i;

    initial
    begin
        ser_rx_o = 1'h1;
        ir_rx_o  = 1'h0;
    end

    // Infrared zero bit is a high pulse; the unused pin keeps its idle level
    task automatic send(input ushb_byte_t d, input logic ir);
        logic [9:0] fr;
        fr = {1'h1, d, 1'h0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk_i);
            ser_rx_o <= ir ? 1'h1 : fr[i];
            ir_rx_o  <= ir ? ~fr[i] : 1'h0;
            repeat (BIT_CYC - 1) @(posedge clk_i);
        end
    endtask

    always
    begin
        @(negedge line);
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYC) @(posedge clk_i);
            b[i] = line;
        end
        repeat (BIT_CYC) @(posedge clk_i);
        if (line === 1'h1)
            got_q.push_back(b);
        else
            bad_frames++;
    end
endmodule // ushb_peer_model

/* File: testbench/ushb_top_bench.sv */
// Self-checking bench for the UART shadow buffer access block
// Assumes: design files and the peer model are compiled before it
`include "ushb_consts.svh"
`define USHB_CHK(nm, e, g) \
    begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module ushb_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import ushb_pkg::*;
    localparam int BC    = 8;
    localparam int FD    = 4;
    localparam int LIMIT = 10000;
    typedef struct packed {
        logic        wr;
        logic [31:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic        err;
    } ushb_row_t;
    localparam ushb_row_t ROWS [11] = '{
        '{1'h0, `USHB_LSR_ADDR, 32'h0, 32'h60, 1'h0},
        '{1'h0, `USHB_CTRL_ADDR, 32'h0, 32'h0, 1'h0},
        '{1'h0, `USHB_ISTAT_ADDR, 32'h0, 32'h0, 1'h0},
        '{1'h0, `USHB_ALIAS_2, 32'h0, 32'h0, 1'h0},
        '{1'h0, 32'h5000_1090, 32'h0, 32'h0, 1'h1},
        '{1'h1, 32'h5000_1090, 32'hffff_ffff, 32'h0, 1'h1},
        '{1'h1, `USHB_IMASK_ADDR, 32'h7, 32'h0, 1'h0},
        '{1'h0, `USHB_IMASK_ADDR, 32'h0, 32'h7, 1'h0},
        '{1'h1, `USHB_IMASK_ADDR, 32'h0, 32'h0, 1'h0},
        '{1'h0, 32'h5000_102c, 32'h0, 32'h0, 1'h1},
        '{1'h0, `USHB_ALIAS_LAST, 32'h0, 32'h0, 1'h0}};
    logic        clk     = 1'h0;
    logic        rstn    = 1'h0;
    logic        psel    = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite  = 1'h0;
    logic [31:0] paddr   = 32'h0;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, ser_rx, ir_rx, ser_tx, ir_tx_n, irq;
    logic [31:0] v;
    logic        e;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc       = 0;
    int          n;

    ushb_top #(.FIFO_DEPTH(FD), .BIT_CYC(BC)) i_ushb_top (
        .clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .ser_rx_i(ser_rx), .ir_rx_i(ir_rx),
        .ser_tx_o(ser_tx), .ir_tx_n_o(ir_tx_n), .irq_o(irq));
    ushb_peer_model #(.BIT_CYC(BC)) i_ushb_peer_model (
        .clk_i(clk), .ser_tx_i(ser_tx), .ir_tx_n_i(ir_tx_n),
        .ser_rx_o(ser_rx), .ir_rx_o(ir_rx));

    always #25 clk = ~clk;

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            bad_count++;
            finish_test();
        end
    end

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'h1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        // Only the bench timeout ends this wait
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        `USHB_CHK("apb_ready", 1'h1, pready)
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        x;
        apb(1'h1, a, d, r, x);
    endtask

    task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] ex);
        logic [31:0] r;
        logic        x;
        apb(1'h0, a, 32'h0, r, x);
        `USHB_CHK(nm, ex, r)
    endtask

    task automatic qchk(input ushb_byte_t ex[]);
        `USHB_CHK("peer_count", ex.size(), i_ushb_peer_model.got_q.size())
        `USHB_CHK("peer_bad", 0, i_ushb_peer_model.bad_frames)
        foreach (ex[i])
            `USHB_CHK("peer_byte", ex[i], i_ushb_peer_model.got_q[i])
        i_ushb_peer_model.got_q.delete();
    endtask

    task automatic reset_chk();
        @(posedge clk);
        rstn <= 1'h0;
        repeat (3) @(posedge clk);
        `USHB_CHK("ser_tx_idle", 1'h1, ser_tx)
        `USHB_CHK("ir_tx_idle", 1'h1, ir_tx_n)
        rstn <= 1'h1;
    endtask

    initial
    begin
        reset_chk();
        foreach (ROWS[i])
        begin
            apb(ROWS[i].wr, ROWS[i].a, ROWS[i].d, v, e);
            if (!ROWS[i].wr)
                `USHB_CHK("row_rdata", ROWS[i].e, v)
            `USHB_CHK("row_err", ROWS[i].err, e)
        end
        // Holding register without FIFO: third write replaces the pending byte
        wr(`USHB_ALIAS_2, 32'hffff_ffa5);
        wr(`USHB_ALIAS_3, 32'h11);
        rdchk("lsr_busy", `USHB_LSR_ADDR, 32'h0);
        wr(`USHB_ALIAS_3, 32'h22);
        repeat (30 * BC) @(posedge clk);
        qchk('{8'ha5, 8'h22});
        // FIFO mode: one byte to the shifter, depth bytes held, the rest dropped
        wr(`USHB_CTRL_ADDR, 32'h1);
        rdchk("lsr_tx_holding_empty_flag", `USHB_LSR_ADDR, 32'h60);
        for (int i = 0; i < FD + 2; i++)
            wr(`USHB_ALIAS_FIRST + 32'(4 * i), 32'h30 + 32'(i));
        rdchk("lsr_full", `USHB_LSR_ADDR, 32'h0);
        repeat ((FD + 3) * 10 * BC) @(posedge clk);
        qchk('{8'h30, 8'h31, 8'h32, 8'h33, 8'h34});
        wr(`USHB_CTRL_ADDR, 32'h2);
        wr(`USHB_ALIAS_2, 32'h96);
        n = 0;
        repeat (12 * BC)
        begin
            @(posedge clk);
            n += (ser_tx !== 1'h1);
        end
        `USHB_CHK("ser_held", 0, n)
        qchk('{8'h96});
        // Receive without FIFO: an unread byte is overwritten
        wr(`USHB_CTRL_ADDR, 32'h0);
        i_ushb_peer_model.send(8'h5a, 1'h0);
        repeat (BC) @(posedge clk);
        rdchk("lsr_dr", `USHB_LSR_ADDR, 32'h61);
        rdchk("rx_byte", `USHB_ALIAS_3, 32'h5a);
        i_ushb_peer_model.send(8'h12, 1'h0);
        i_ushb_peer_model.send(8'h34, 1'h0);
        repeat (BC) @(posedge clk);
        rdchk("lsr_oe", `USHB_LSR_ADDR, 32'h63);
        rdchk("rx_over", `USHB_ALIAS_2, 32'h34);
        // Receive FIFO overflows by one byte
        wr(`USHB_CTRL_ADDR, 32'h1);
        for (int i = 1; i <= FD + 1; i++)
            i_ushb_peer_model.send(8'(i), 1'h0);
        repeat (BC) @(posedge clk);
        rdchk("lsr_fifo_oe", `USHB_LSR_ADDR, 32'h63);
        for (int i = 1; i <= FD; i++)
            rdchk("rx_head", `USHB_ALIAS_FIRST + 32'(4 * i), 32'(i));
        rdchk("lsr_empty", `USHB_LSR_ADDR, 32'h60);
        // Infrared receive raises the event, masked then unmasked, then cleared
        wr(`USHB_CTRL_ADDR, 32'h2);
        wr(`USHB_ISTAT_ADDR, 32'h7);
        i_ushb_peer_model.send(8'hc3, 1'h1);
        repeat (BC) @(posedge clk);
        rdchk("ev_rx", `USHB_ISTAT_ADDR, 32'h1);
        `USHB_CHK("irq_masked", 1'h0, irq)
        wr(`USHB_IMASK_ADDR, 32'h1);
        repeat (2) @(posedge clk);
        `USHB_CHK("irq_set", 1'h1, irq)
        rdchk("rx_ir", `USHB_ALIAS_LAST, 32'hc3);
        wr(`USHB_ISTAT_ADDR, 32'h1);
        repeat (2) @(posedge clk);
        `USHB_CHK("irq_clr", 1'h0, irq)
        // Reset in mid-frame
        wr(`USHB_ALIAS_2, 32'h55);
        repeat (3 * BC) @(posedge clk);
        reset_chk();
        rdchk("ctrl_rst", `USHB_CTRL_ADDR, 32'h0);
        rdchk("alias_rst", `USHB_ALIAS_2, 32'h0);
        finish_test();
    end
endmodule // ushb_top_bench
